//--- src/udbss_top.sv
//
// Function
// - ignore requests until first bus reset
// - SE0 past threshold means bus reset
// - bus reset clears address, enters Default
// - bus reset selects Report, flushes IN
// - bus reset restores power-on register values
// - long bus idle means suspend request
// - start suspend between 5 and 6 ms
// - enters suspend at once, current frame not finished first
// - remote resume needs enable and button
// - drive remote resume 11.45 to 12.45 ms
// - device status: self powered, remote wake
// - device status accepted in all live states
// - set/clear feature toggles remote wakeup
// - interface status stalls unless Configured
// - interface status returns two zero bytes
// - suspend enters low power, activity leaves
//
module udbss_top #(
    parameter int RESET_CYC = udbss_pkg::RESET_DET_CYC,
    parameter int SUSP_CYC  = udbss_pkg::SUSP_CYC,
    parameter int WAKE_CYC  = udbss_pkg::WAKE_CYC
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // usb line pins
    input  wire logic                  dpIn,
    input  wire logic                  dmIn,
    output logic                       dpOut,
    output logic                       dmOut,
    output logic                       lineOe,
    // button pin
    input  wire logic                  buttonIn,
    // request port from the serial engine
    input  wire logic                  reqValid,
    input  wire udbss_pkg::udbss_req_t req,
    output logic                       rspValid,
    output udbss_pkg::udbss_rsp_t      rsp,
    // device side effects
    output logic                       flushIn,
    output logic                       lowPower,
    // axi4-lite slave
    input  wire logic [3:0]            awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [3:0]            araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready
);

    //--------------------------------------------------------------
    // pin synchronisers
    //--------------------------------------------------------------
    logic [2:0] syncA_reg;     // first stage, read only by second
    logic [2:0] syncB_reg;     // dp, dm, button after two flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // start from idle J so no false SE0 is timed after reset
            syncA_reg <= 3'h1;
            syncB_reg <= 3'h1;
        end else begin
            syncA_reg <= {buttonIn, dmIn, dpIn};
            syncB_reg <= syncA_reg;
        end
    end
    logic lineSe0, lineIdle, button;
    assign lineSe0  = !syncB_reg[0] && !syncB_reg[1];   // both lines low
    assign lineIdle = syncB_reg[0] && !syncB_reg[1];    // full-speed J
    assign button   = syncB_reg[2];

    //--------------------------------------------------------------
    // axi4-lite slave
    //--------------------------------------------------------------
    logic [3:0]  awAddr_reg,  awAddr_next;   // held write address
    logic        awHave_reg,  awHave_next;
    logic [31:0] wData_reg,   wData_next;    // held write data
    logic        wLow_reg,    wLow_next;     // byte lane 0 enabled
    logic        wHave_reg,   wHave_next;
    logic        bValid_reg,  bValid_next;
    logic [1:0]  bResp_reg,   bResp_next;
    logic        rValid_reg,  rValid_next;
    logic [31:0] rData_reg,   rData_next;
    logic [1:0]  rResp_reg,   rResp_next;
    logic        ctrlWrite;                  // one-cycle write of CTRL
    logic [31:0] statusWord;                 // live device state
    logic        selfPow_reg, selfPow_next;  // self powered, CTRL bit 0

    assign awready = !awHave_reg && !bValid_reg;
    assign wready  = !wHave_reg && !bValid_reg;
    assign arready = !rValid_reg;
    assign bvalid  = bValid_reg;
    assign bresp   = bResp_reg;
    assign rvalid  = rValid_reg;
    assign rdata   = rData_reg;
    assign rresp   = rResp_reg;

    // address and data may arrive in either order; commit once both held
    always_comb begin
        awAddr_next = awAddr_reg;
        awHave_next = awHave_reg;
        wData_next  = wData_reg;
        wLow_next   = wLow_reg;
        wHave_next  = wHave_reg;
        bValid_next = bValid_reg;
        bResp_next  = bResp_reg;
        rValid_next = rValid_reg;
        rData_next  = rData_reg;
        rResp_next  = rResp_reg;
        ctrlWrite   = 1'b0;
        if (awvalid && awready) begin
            awAddr_next = awaddr;
            awHave_next = 1'b1;
        end
        if (wvalid && wready) begin
            wData_next = wdata;
            wLow_next  = wstrb[0];
            wHave_next = 1'b1;
        end
        if (awHave_reg && wHave_reg) begin
            awHave_next = 1'b0;
            wHave_next  = 1'b0;
            bValid_next = 1'b1;
            // status is read-only: writes there are accepted and dropped
            if (awAddr_reg == udbss_pkg::ADDR_CTRL) begin
                ctrlWrite  = wLow_reg;
                bResp_next = udbss_pkg::RESP_OKAY;
            end else if (awAddr_reg == udbss_pkg::ADDR_STATUS) begin
                bResp_next = udbss_pkg::RESP_OKAY;
            end else begin
                bResp_next = udbss_pkg::RESP_DECERR;
            end
        end
        if (bValid_reg && bready) begin
            bValid_next = 1'b0;
        end
        if (arvalid && arready) begin
            rValid_next = 1'b1;
            rResp_next  = udbss_pkg::RESP_OKAY;
            case (araddr)
                udbss_pkg::ADDR_CTRL:   rData_next = {31'h0, selfPow_reg};
                udbss_pkg::ADDR_STATUS: rData_next = statusWord;
                default: begin
                    rData_next = 32'h0;
                    rResp_next = udbss_pkg::RESP_DECERR;
                end
            endcase
        end else if (rValid_reg && rready) begin
            rValid_next = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awAddr_reg <= 4'h0;
            awHave_reg <= 1'b0;
            wData_reg  <= 32'h0;
            wLow_reg   <= 1'b0;
            wHave_reg  <= 1'b0;
            bValid_reg <= 1'b0;
            bResp_reg  <= 2'h0;
            rValid_reg <= 1'b0;
            rData_reg  <= 32'h0;
            rResp_reg  <= 2'h0;
        end else begin
            awAddr_reg <= awAddr_next;
            awHave_reg <= awHave_next;
            wData_reg  <= wData_next;
            wLow_reg   <= wLow_next;
            wHave_reg  <= wHave_next;
            bValid_reg <= bValid_next;
            bResp_reg  <= bResp_next;
            rValid_reg <= rValid_next;
            rData_reg  <= rData_next;
            rResp_reg  <= rResp_next;
        end
    end

    //--------------------------------------------------------------
    // usb bus state, suspend, resume and requests
    //--------------------------------------------------------------
    udbss_pkg::udbss_state_t state_reg, state_next;   // usb device state
    logic [6:0]              addr_reg,  addr_next;    // assigned address
    logic                    wake_reg,  wake_next;    // remote wakeup enable
    logic                    proto_reg, proto_next;   // 1 = report protocol
    logic                    seen_reg,  seen_next;    // first reset received
    logic                    susp_reg,  susp_next;    // suspended
    logic                    drive_reg, drive_next;   // driving resume K
    logic                    btnPrev_reg, btnPrev_next;
    logic                    flush_reg, flush_next;
    logic                    rspV_reg,  rspV_next;
    udbss_pkg::udbss_rsp_t   rsp_reg,   rsp_next;
    logic [udbss_pkg::CNT_W-1:0] se0Cnt_reg,  se0Cnt_next;
    logic [udbss_pkg::CNT_W-1:0] idleCnt_reg, idleCnt_next;
    logic [udbss_pkg::CNT_W-1:0] wakeCnt_reg, wakeCnt_next;
    logic                    busReset;                // one-cycle reset event

    localparam logic [udbss_pkg::CNT_W-1:0] RESET_LAST = (udbss_pkg::CNT_W)'(RESET_CYC - 1);
    localparam logic [udbss_pkg::CNT_W-1:0] SUSP_LAST  = (udbss_pkg::CNT_W)'(SUSP_CYC - 1);
    localparam logic [udbss_pkg::CNT_W-1:0] WAKE_LAST  = (udbss_pkg::CNT_W)'(WAKE_CYC - 1);

    assign statusWord = {18'h0, addr_reg, seen_reg, proto_reg, drive_reg, susp_reg,
                         wake_reg, state_reg};
    assign busReset = lineSe0 && (se0Cnt_reg == RESET_LAST);

    always_comb begin
        state_next   = state_reg;
        addr_next    = addr_reg;
        wake_next    = wake_reg;
        proto_next   = proto_reg;
        seen_next    = seen_reg;
        susp_next    = susp_reg;
        drive_next   = drive_reg;
        selfPow_next = ctrlWrite ? wData_reg[udbss_pkg::CTRL_SELF_BIT] : selfPow_reg;
        btnPrev_next = button;
        flush_next   = 1'b0;
        rspV_next    = 1'b0;
        rsp_next     = rsp_reg;
        se0Cnt_next  = (lineSe0 && se0Cnt_reg != RESET_LAST) ? se0Cnt_reg + 1'b1 : '0;
        idleCnt_next = (lineIdle && !susp_reg && !drive_reg && idleCnt_reg != SUSP_LAST)
                       ? idleCnt_reg + 1'b1 : '0;
        wakeCnt_next = drive_reg ? wakeCnt_reg + 1'b1 : '0;
        if (busReset) begin
            state_next   = udbss_pkg::ST_DEFAULT;
            addr_next    = 7'h00;
            proto_next   = 1'b1;
            flush_next   = 1'b1;
            wake_next    = 1'b0;
            selfPow_next = udbss_pkg::SELF_POW_RST;
            susp_next    = 1'b0;
            drive_next   = 1'b0;
            seen_next    = 1'b1;
        end else if (drive_reg) begin
            // hold K for the fixed length
            if (wakeCnt_reg == WAKE_LAST) begin
                drive_next = 1'b0;
            end
        end else if (susp_reg) begin
            // wake only if enabled and pressed
            if (wake_reg && button && !btnPrev_reg) begin
                drive_next = 1'b1;
                susp_next  = 1'b0;
            end else if (!lineIdle) begin
                susp_next = 1'b0;
            end
        // entered at 5 ms of idle
        // no frame tail is kept, so entry is immediate
        end else if (lineIdle && idleCnt_reg == SUSP_LAST) begin
            susp_next = 1'b1;
        end else if (reqValid && seen_reg) begin
            rspV_next      = 1'b1;
            rsp_next.stall = 1'b0;
            rsp_next.data  = 16'h0000;
            case (req.kind)
                // self powered bit 0, wakeup bit 1
                udbss_pkg::RQ_GET_STAT_DEV: rsp_next.data = {14'h0000, wake_reg, selfPow_reg};
                udbss_pkg::RQ_GET_STAT_IF:
                    rsp_next.stall = (state_reg != udbss_pkg::ST_CONFIGURED);
                udbss_pkg::RQ_SET_FEAT_DEV: wake_next = 1'b1;
                udbss_pkg::RQ_CLR_FEAT_DEV: wake_next = 1'b0;
                udbss_pkg::RQ_SET_ADDRESS: begin
                    addr_next  = req.value[6:0];
                    state_next = (req.value[6:0] == 7'h00) ? udbss_pkg::ST_DEFAULT
                                                           : udbss_pkg::ST_ADDRESSED;
                end
                udbss_pkg::RQ_SET_CONFIG: begin
                    if (state_reg == udbss_pkg::ST_DEFAULT) begin
                        rsp_next.stall = 1'b1;
                    end else begin
                        state_next = (req.value == 8'h01) ? udbss_pkg::ST_CONFIGURED
                                                          : udbss_pkg::ST_ADDRESSED;
                    end
                end
                udbss_pkg::RQ_SET_PROTO: proto_next = req.value[0];
                default: rsp_next.stall = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg   <= udbss_pkg::ST_ATTACHED;
            addr_reg    <= 7'h00;
            wake_reg    <= 1'b0;
            proto_reg   <= 1'b1;
            seen_reg    <= 1'b0;
            susp_reg    <= 1'b0;
            drive_reg   <= 1'b0;
            selfPow_reg <= udbss_pkg::SELF_POW_RST;
            btnPrev_reg <= 1'b0;
            flush_reg   <= 1'b0;
            rspV_reg    <= 1'b0;
            rsp_reg     <= '0;
            se0Cnt_reg  <= '0;
            idleCnt_reg <= '0;
            wakeCnt_reg <= '0;
        end else begin
            state_reg   <= state_next;
            addr_reg    <= addr_next;
            wake_reg    <= wake_next;
            proto_reg   <= proto_next;
            seen_reg    <= seen_next;
            susp_reg    <= susp_next;
            drive_reg   <= drive_next;
            selfPow_reg <= selfPow_next;
            btnPrev_reg <= btnPrev_next;
            flush_reg   <= flush_next;
            rspV_reg    <= rspV_next;
            rsp_reg     <= rsp_next;
            se0Cnt_reg  <= se0Cnt_next;
            idleCnt_reg <= idleCnt_next;
            wakeCnt_reg <= wakeCnt_next;
        end
    end

    // resume K: dp low, dm high
    assign dpOut    = 1'b0;
    assign dmOut    = drive_reg;
    assign lineOe   = drive_reg;
    assign lowPower = susp_reg;
    assign flushIn  = flush_reg;
    assign rspValid = rspV_reg;
    assign rsp      = rsp_reg;

    //--------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence quietReq_s;
        reqValid && !seen_reg && !busReset;
    endsequence

    no_early_answer_a: assert property (quietReq_s |=> !rspValid)
        else $error("request answered before first bus reset");
    reset_after_se0_a: assert property (busReset |-> $past(lineSe0))
        else $error("bus reset without preceding SE0");
    reset_state_a: assert property (busReset |=> state_reg == udbss_pkg::ST_DEFAULT
                                     && addr_reg == 7'h00)
        else $error("bus reset left state or address");
    reset_proto_a: assert property (busReset |=> flushIn && proto_reg ##1 !flushIn)
        else $error("bus reset did not select report and flush once");
    reset_regs_a: assert property (busReset |=> !wake_reg && !susp_reg
                                   && selfPow_reg == udbss_pkg::SELF_POW_RST)
        else $error("bus reset left a register changed");
    suspend_entry_a: assert property ($rose(susp_reg) |-> $past(idleCnt_reg) == SUSP_LAST)
        else $error("suspend entered at wrong idle length");
    wake_cause_a: assert property ($rose(drive_reg) |-> $past(wake_reg && susp_reg
                                   && button))
        else $error("remote resume without enable and press");
    wake_length_a: assert property ($fell(drive_reg) && !$past(busReset)
                                    |-> $past(wakeCnt_reg) == WAKE_LAST)
        else $error("remote resume length wrong");
    dev_status_a: assert property (reqValid && seen_reg && !busReset && !susp_reg
                                   && !drive_reg && !lineIdle
                                   && req.kind == udbss_pkg::RQ_GET_STAT_DEV
                                   |=> rspValid && !rsp.stall
                                   && rsp.data == {14'h0000, $past(wake_reg),
                                   $past(selfPow_reg)})
        else $error("device status answer wrong");
    feature_a: assert property (rspValid && !rsp.stall && $past(req.kind)
                                == udbss_pkg::RQ_SET_FEAT_DEV |-> wake_reg)
        else $error("set feature did not enable wakeup");
    if_status_a: assert property (rspValid && $past(req.kind) == udbss_pkg::RQ_GET_STAT_IF
                                  |-> rsp.stall == ($past(state_reg)
                                  != udbss_pkg::ST_CONFIGURED) && rsp.data == 16'h0000)
        else $error("interface status answer wrong");
    low_power_exit_a: assert property (susp_reg && !lineIdle && !busReset
                                       |=> !lowPower)
        else $error("activity did not leave low power");

endmodule

//--- src/udbss_pkg.sv
package udbss_pkg;

    //--------------------------------------------------------------
    // clock and timing
    //--------------------------------------------------------------
    localparam int CLK_MHZ        = 100;     // system clock rate
    localparam int RESET_LEGAL_NS = 18700;   // shortest SE0 that may count as bus reset
    localparam int RESET_LATE_MS  = 10;      // SE0 by which reset must be seen
    localparam int RESET_DET_US   = 100;     // chosen detection point, inside the window
    localparam int SUSP_LEGAL_MS  = 3;       // shortest idle that may count as suspend
    localparam int SUSP_MIN_US    = 5000;    // earliest start of suspend entry
    localparam int SUSP_MAX_US    = 6000;    // latest start of suspend entry
    localparam int WAKE_MIN_US    = 11450;   // shortest remote resume drive
    localparam int WAKE_MAX_US    = 12450;   // longest remote resume drive
    // cycle counts, least times rounded up
    localparam int RESET_DET_CYC  = RESET_DET_US * CLK_MHZ;
    localparam int SUSP_CYC       = SUSP_MIN_US * CLK_MHZ;
    localparam int WAKE_CYC       = WAKE_MIN_US * CLK_MHZ;
    localparam int CNT_W          = 24;      // wide enough for the longest count

    //--------------------------------------------------------------
    // register map (byte addresses)
    //--------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;  // bit0 self powered
    localparam logic [3:0] ADDR_STATUS = 4'h4;  // read-only device state
    localparam int         CTRL_SELF_BIT = 0;
    localparam logic       SELF_POW_RST  = 1'b0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    //--------------------------------------------------------------
    // usb device states and request kinds
    //--------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_ATTACHED   = 2'b00,
        ST_DEFAULT    = 2'b01,
        ST_ADDRESSED  = 2'b10,
        ST_CONFIGURED = 2'b11
    } udbss_state_t;

    typedef enum logic [2:0] {
        RQ_GET_STAT_DEV = 3'b000,
        RQ_GET_STAT_IF  = 3'b001,
        RQ_SET_FEAT_DEV = 3'b010,
        RQ_CLR_FEAT_DEV = 3'b011,
        RQ_SET_ADDRESS  = 3'b100,
        RQ_SET_CONFIG   = 3'b101,
        RQ_SET_PROTO    = 3'b110,
        RQ_OTHER        = 3'b111
    } udbss_kind_t;

    // decoded setup request from the serial engine
    typedef struct packed {
        udbss_kind_t kind;
        logic [7:0]  value;   // wValue low byte
    } udbss_req_t;

    // answer to a request: stall or two data bytes, byte 0 low
    typedef struct packed {
        logic        stall;
        logic [15:0] data;
    } udbss_rsp_t;

endpackage

//--- bench/udbss_host.sv
module udbss_host (
    // bus level asked of the host: 0 idle J, 1 SE0, 2 K
    input  wire logic [1:0] lineCmd,
    // device side of the pins
    input  wire logic       dpOut,
    input  wire logic       dmOut,
    input  wire logic       lineOe,
    // levels seen by the device receiver
    output logic            dpIn,
    output logic            dmIn
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------
    // wire resolution
    // ----------------------------------------------------------
    // the device wins the wire while it drives resume; the host backs off
    always_comb begin
        if (lineOe) begin
            dpIn = dpOut;
            dmIn = dmOut;
        end else begin
            case (lineCmd)
                2'h1: {dpIn, dmIn} = 2'b00;
                2'h2: {dpIn, dmIn} = 2'b01;
                // idle J held by the pull-up
                default: {dpIn, dmIn} = 2'b10;
            endcase
        end
    end
endmodule

//--- bench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // shortened counts keep the run brief
    localparam int RC = 8;
    localparam int SC = 50;
    localparam int WC = 40;
    logic clk, rst, dpIn, dmIn, dpOut, dmOut, lineOe, buttonIn, reqValid, rspValid;
    logic flushIn, lowPower, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] lineCmd, bresp, rresp, rr;
    logic [3:0] awaddr, wstrb, araddr;
    logic [31:0] wdata, rdata, rd;
    udbss_pkg::udbss_req_t req;
    udbss_pkg::udbss_rsp_t rsp;
    int errors, total_checks, n;

    udbss_top #(.RESET_CYC(RC), .SUSP_CYC(SC), .WAKE_CYC(WC)) u_udbss_top (.clk, .rst,
        .dpIn, .dmIn, .dpOut, .dmOut, .lineOe, .buttonIn, .reqValid, .req, .rspValid,
        .rsp, .flushIn, .lowPower, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);
    udbss_host u_udbss_host (.lineCmd, .dpOut, .dmOut, .lineOe, .dpIn, .dmIn);

    always #5 clk = ~clk;

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // a wait that ran out is a failure
    task automatic giveup(input int k);
        if (k >= 2000) begin
            errors++;
            wrap_up();
        end
    endtask

    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each channel drops on its own ready, then wait for the answer
        do begin
            @(posedge clk);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            rr = bresp;
        end while (bvalid !== 1'b1 && k < 2000);
        bready <= 1'b0;
        giveup(k);
    endtask

    task automatic axr(input logic [3:0] a);
        int k;
        k = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (arready) arvalid <= 1'b0;
            rd = rdata;
            rr = rresp;
        end while (rvalid !== 1'b1 && k < 2000);
        rready <= 1'b0;
        giveup(k);
    endtask

    // data is compared only for the status requests that answer
    task automatic rq(input udbss_pkg::udbss_kind_t k, input logic [7:0] v, input logic want,
                      input logic [16:0] exp);
        @(posedge clk);
        reqValid <= 1'b1;
        req <= {k, v};
        @(posedge clk);
        reqValid <= 1'b0;
        #1;
        chk("rspValid", rspValid, want);
        if (want) chk("stall", rsp.stall, exp[16]);
        if (want && !exp[16] && k inside {udbss_pkg::RQ_GET_STAT_DEV, udbss_pkg::RQ_GET_STAT_IF})
            chk("rspData", rsp.data, exp[15:0]);
    endtask

    task automatic line(input logic [1:0] c);
        @(posedge clk);
        lineCmd <= c;
    endtask

    // which: 0 flushIn, 1 lowPower, 2 lineOe; n ends as cycles waited
    task automatic waitfor(input int which, input logic want);
        logic v;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            v = (which == 0) ? flushIn : (which == 1) ? lowPower : lineOe;
        end while (v !== want && n < 2000);
        giveup(n);
    endtask

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        {clk, buttonIn, reqValid, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, req} = '0;
        rst = 1'b1;
        lineCmd = 2'h2;
        wstrb = 4'hF;
        errors = 0;
        total_checks = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rq(udbss_pkg::RQ_GET_STAT_DEV, 8'h00, 1'b0, '0);
        axw(4'h0, 32'h1);
        chk("writeResp", rr, udbss_pkg::RESP_OKAY);
        axr(4'h8);
        chk("unmapped", rr, udbss_pkg::RESP_DECERR);
        line(2'h1);
        waitfor(0, 1'b1);
        chk("resetTime", n >= RC && n <= RC + 6, 1);
        line(2'h2);
        axr(4'h0);
        chk("ctrlCleared", rd, 32'h0);
        axr(4'h4);
        chk("status", rd, 32'h61);
        rq(udbss_pkg::RQ_GET_STAT_DEV, 8'h00, 1'b1, 17'h0);
        rq(udbss_pkg::RQ_GET_STAT_IF, 8'h00, 1'b1, 17'h10000);
        axw(4'h0, 32'h1);
        rq(udbss_pkg::RQ_SET_FEAT_DEV, 8'h01, 1'b1, 17'h0);
        rq(udbss_pkg::RQ_GET_STAT_DEV, 8'h00, 1'b1, 17'h3);
        rq(udbss_pkg::RQ_CLR_FEAT_DEV, 8'h01, 1'b1, 17'h0);
        rq(udbss_pkg::RQ_GET_STAT_DEV, 8'h00, 1'b1, 17'h1);
        rq(udbss_pkg::RQ_SET_ADDRESS, 8'h05, 1'b1, 17'h0);
        rq(udbss_pkg::RQ_GET_STAT_IF, 8'h00, 1'b1, 17'h10000);
        rq(udbss_pkg::RQ_GET_STAT_DEV, 8'h00, 1'b1, 17'h1);
        rq(udbss_pkg::RQ_SET_CONFIG, 8'h01, 1'b1, 17'h0);
        rq(udbss_pkg::RQ_GET_STAT_IF, 8'h00, 1'b1, 17'h0);
        axr(4'h4);
        chk("statusCfg", rd, 32'h2E3);
        rq(udbss_pkg::RQ_SET_FEAT_DEV, 8'h01, 1'b1, 17'h0);
        // idle until suspend, then wake by the button
        line(2'h0);
        waitfor(1, 1'b1);
        chk("suspendTime", n >= SC && n <= SC + 6, 1);
        rq(udbss_pkg::RQ_GET_STAT_DEV, 8'h00, 1'b0, '0);
        @(posedge clk);
        buttonIn <= 1'b1;
        waitfor(2, 1'b1);
        chk("wakeLowPower", lowPower, 0);
        chk("resumeK", {dpOut, dmOut}, 2'b01);
        waitfor(2, 1'b0);
        chk("wakeLength", n, WC);
        line(2'h2);
        buttonIn <= 1'b0;
        // host answers with its own resume and recovery gap
        repeat (30) @(posedge clk);
        rq(udbss_pkg::RQ_CLR_FEAT_DEV, 8'h01, 1'b1, 17'h0);
        line(2'h0);
        waitfor(1, 1'b1);
        @(posedge clk);
        buttonIn <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk("noWake", lineOe, 0);
        line(2'h2);
        waitfor(1, 1'b0);
        chk("activityExit", n <= 5, 1);
        // leave protocol, wakeup and self powered changed before the reset
        rq(udbss_pkg::RQ_SET_PROTO, 8'h00, 1'b1, 17'h0);
        rq(udbss_pkg::RQ_SET_FEAT_DEV, 8'h01, 1'b1, 17'h0);
        axw(4'h0, 32'h1);
        line(2'h1);
        waitfor(0, 1'b1);
        line(2'h2);
        axr(4'h4);
        chk("statusReset", rd, 32'h61);
        axr(4'h0);
        chk("ctrlReset", rd, 32'h0);
        wrap_up();
    end
endmodule
